// [rtl/ccm_regs.vh]
// Register offsets, field positions and reset values of the coefficient top-bit words
`ifndef CCM_REGS_VH
`define CCM_REGS_VH

// ----------------------------------------------------------------------------
// Word offsets
// ----------------------------------------------------------------------------
`define CCM_ADDR_W            5
`define CCM_OFF_BRIDGE        5'h03
`define CCM_OFF_TSENSOR       5'h04
`define CCM_OFF_OFFSET_B      5'h05
`define CCM_OFF_GAIN_B        5'h06
`define CCM_OFF_TCG           5'h07
`define CCM_OFF_TCO           5'h08
`define CCM_OFF_TCO_SECOND    5'h09
`define CCM_OFF_TCG_SECOND    5'h0a
`define CCM_OFF_BRIDGE_NL     5'h0b
`define CCM_OFF_OFFSET_T      5'h0c
`define CCM_OFF_GAIN_T        5'h0d
`define CCM_OFF_TS_SECOND     5'h0e

// ----------------------------------------------------------------------------
// Field positions in the bridge word
// ----------------------------------------------------------------------------
`define CCM_BIT_OFFSET_B_MSB  0
`define CCM_BIT_OFFSET_B_SGN  1
`define CCM_BIT_GAIN_B_MSB    2
`define CCM_BIT_GAIN_B_SGN    3
`define CCM_BIT_TCG_MSB       4
`define CCM_BIT_TCG_SGN       5
`define CCM_BIT_TCO_MSB       6
`define CCM_BIT_TCO_SGN       7
`define CCM_BIT_TCO2_MSB      8
`define CCM_BIT_TCO2_SGN      9
`define CCM_BIT_TCG2_MSB      10
`define CCM_BIT_TCG2_SGN      11
`define CCM_BIT_NL_MSB        12
`define CCM_BIT_NL_SGN        13
`define CCM_BIT_CURVE         14
`define CCM_BIT_SETTLE_SGN    15

// ----------------------------------------------------------------------------
// Field positions in the temperature-sensor word
// ----------------------------------------------------------------------------
`define CCM_BIT_GAIN_T_MSB    0
`define CCM_BIT_GAIN_T_SGN    1
`define CCM_BIT_TS2_MSB       2
`define CCM_BIT_TS2_SGN       3
`define CCM_BIT_OFFSET_T_MSB  4
`define CCM_BIT_OFFSET_T_SGN  5
`define CCM_TS_USED_MASK      16'h003f

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCM_RST_BRIDGE        16'h0000
`define CCM_RST_TSENSOR       16'h0000
`define CCM_RST_LOW           16'h0000

`endif

// [rtl/ccm_word_mem.v]
// Small memory for the sixteen-bit low magnitude words, registered read
`timescale 1ns/10ps
`default_nettype none
`include "ccm_regs.vh"
module ccm_word_mem (
    input  wire         clk_in,
    input  wire         reset_in,
    input  wire         wr_en_in,
    input  wire [3:0]   wr_addr_in,
    input  wire [15:0]  wr_data_in,
    input  wire [3:0]   rd_addr_in,
    output reg  [15:0]  rd_data_out,
    output wire [159:0] flat_out
);
    reg [15:0] mem_reg [0:9];

    // ------------------------------------------------------------------------
    // Storage, read port and flat view for the correction math
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : gen_word
            always @(posedge clk_in) begin
                if (reset_in) begin
                    mem_reg[g] <= `CCM_RST_LOW;
                end else if (wr_en_in && wr_addr_in == g) begin
                    mem_reg[g] <= wr_data_in;
                end
            end
            assign flat_out[g*16 +: 16] = mem_reg[g];
        end
    endgenerate

    // Registered read data
    always @(posedge clk_in) begin
        if (reset_in) begin
            rd_data_out <= 16'h0000;
        end else begin
            rd_data_out <= (rd_addr_in < 4'ha) ? mem_reg[rd_addr_in] : 16'h0000;
        end
    end
endmodule
`default_nettype wire

// [rtl/ccm_coeff_build.v]
// Builds one signed 18-bit coefficient from a top bit, a sign flag and a low word
`timescale 1ns/10ps
`default_nettype none
module ccm_coeff_build (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        msb_in,
    input  wire        sign_in,
    input  wire [15:0] low_in,
    output reg  [17:0] coeff_out
);
    wire [17:0] mag;
    assign mag = {1'b0, msb_in, low_in};

    // ------------------------------------------------------------------------
    // Sign-magnitude to two's complement, registered
    // ------------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (reset_in) begin
            coeff_out <= 18'h00000;
        end else begin
            coeff_out <= sign_in ? (18'h00000 - mag) : mag; // [R1] [R14]
        end
    end
endmodule
`default_nettype wire

// [rtl/ccm_coeff_bank.v]
// Calibration coefficient top-bit and sign words with assembled signed coefficients
//
// How it works
// R1: Each sign flag: clear means positive, set means negative.
// R2: Bridge offset magnitude is word 3 bit 0 over word 05; bit 1 signs.
// R3: Bridge gain magnitude is word 3 bit 2 over word 06; bit 3 signs.
// R4: Gain tempco first order is word 3 bit 4 over word 07; bit 5 signs.
// R5: Offset tempco first order is word 3 bit 6 over word 08; bit 7 signs.
// R6: Offset tempco second order is word 3 bit 8 over word 09; bit 9 signs.
// R7: Gain tempco second order is word 3 bit 10 over word 0a; bit 11 signs.
// R8: Bridge nonlinear term is word 3 bit 12 over word 0b; bit 13 signs.
// R9: Word 3 bit 14 picks curve: 0 parabolic, 1 s-shaped.
// R10: Word 3 bit 15 is settle term polarity: 0 positive, 1 negative.
// R11: Sensor gain is word 4 bit 0 over word 0d; bit 1 signs.
// R12: Sensor second order is word 4 bit 2 over word 0e; bit 3 signs.
// R13: Sensor offset is word 4 bit 4 over word 0c; bit 5 signs.
// R14: Each coefficient leaves as signed value, negated when its sign is set.
// R15: Word 4 bits 15:6 are ignored and read as zero.
`timescale 1ns/10ps
`default_nettype none
`include "ccm_regs.vh"
module ccm_coeff_bank (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire [4:0]  addr_in,
    input  wire [15:0] wr_data_in,
    input  wire        wr_en_in,
    input  wire        rd_en_in,
    output reg  [15:0] rd_data_out,
    output wire [17:0] offset_b_out,
    output wire [17:0] gain_b_out,
    output wire [17:0] gain_tempco_first_out,
    output wire [17:0] offset_tempco_first_out,
    output wire [17:0] offset_tempco_second_out,
    output wire [17:0] gain_tempco_second_out,
    output wire [17:0] bridge_nonlinear_coeff_out,
    output wire [17:0] tsensor_gain_out,
    output wire [17:0] tsensor_second_order_coeff_out,
    output wire [17:0] tsensor_offset_out,
    output reg         curve_shape_select_out,
    output reg         settle_term_polarity_out
);
    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Index of a low magnitude word, or 4'hf when the address is not one
    function [3:0] low_index;
        input [4:0] a;
        begin
            if (a >= `CCM_OFF_OFFSET_B && a <= `CCM_OFF_TS_SECOND) begin
                low_index = a[3:0] - 4'h5;
            end else begin
                low_index = 4'hf;
            end
        end
    endfunction

    reg  [15:0] bridge_reg;
    reg  [15:0] tsensor_reg;
    reg  [15:0] bridge_next;
    reg  [15:0] tsensor_next;
    reg  [4:0]  rd_addr_reg;
    reg         rd_pend_reg;
    wire [15:0] mem_rd_data;
    wire [159:0] low_flat;
    wire [3:0]  wr_idx;
    wire [3:0]  rd_idx;

    assign wr_idx = low_index(addr_in);
    assign rd_idx = low_index(addr_in);

    // ------------------------------------------------------------------------
    // Flag word writes; unused sensor bits are dropped
    // ------------------------------------------------------------------------
    always @* begin
        bridge_next  = bridge_reg;
        tsensor_next = tsensor_reg;
        if (wr_en_in && addr_in == `CCM_OFF_BRIDGE) begin
            bridge_next = wr_data_in;
        end
        if (wr_en_in && addr_in == `CCM_OFF_TSENSOR) begin
            tsensor_next = wr_data_in & `CCM_TS_USED_MASK; // [R15]
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            bridge_reg  <= `CCM_RST_BRIDGE;
            tsensor_reg <= `CCM_RST_TSENSOR;
        end else begin
            bridge_reg  <= bridge_next;
            tsensor_reg <= tsensor_next;
        end
    end

    // ------------------------------------------------------------------------
    // Low magnitude words
    // ------------------------------------------------------------------------
    ccm_word_mem u_mem (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .wr_en_in    (wr_en_in && wr_idx != 4'hf),
        .wr_addr_in  (wr_idx),
        .wr_data_in  (wr_data_in),
        .rd_addr_in  (rd_idx),
        .rd_data_out (mem_rd_data),
        .flat_out    (low_flat)
    );

    // ------------------------------------------------------------------------
    // Read path: data stand in the cycle after the strobe
    // ------------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (reset_in) begin
            rd_addr_reg <= 5'h00;
            rd_pend_reg <= 1'b0;
        end else begin
            rd_addr_reg <= addr_in;
            rd_pend_reg <= rd_en_in;
        end
    end

    always @* begin
        rd_data_out = 16'h0000;
        if (rd_pend_reg) begin
            if (rd_addr_reg == `CCM_OFF_BRIDGE) begin
                rd_data_out = bridge_reg;
            end else if (rd_addr_reg == `CCM_OFF_TSENSOR) begin
                rd_data_out = tsensor_reg & `CCM_TS_USED_MASK; // [R15]
            end else if (low_index(rd_addr_reg) != 4'hf) begin
                rd_data_out = mem_rd_data;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode flags for the correction math
    // ------------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (reset_in) begin
            curve_shape_select_out   <= 1'b0;
            settle_term_polarity_out <= 1'b0;
        end else begin
            curve_shape_select_out   <= bridge_reg[`CCM_BIT_CURVE];      // [R9]
            settle_term_polarity_out <= bridge_reg[`CCM_BIT_SETTLE_SGN]; // [R10]
        end
    end

    // ------------------------------------------------------------------------
    // Coefficient assembly, one builder per coefficient
    // ------------------------------------------------------------------------
    // Low word slot: offset minus five
    wire [17:0] coeff [0:9];
    wire [9:0]  msb_bits;
    wire [9:0]  sgn_bits;

    assign msb_bits = {tsensor_reg[`CCM_BIT_TS2_MSB],        // [R12]
                       tsensor_reg[`CCM_BIT_GAIN_T_MSB],     // [R11]
                       tsensor_reg[`CCM_BIT_OFFSET_T_MSB],   // [R13]
                       bridge_reg[`CCM_BIT_NL_MSB],          // [R8]
                       bridge_reg[`CCM_BIT_TCG2_MSB],        // [R7]
                       bridge_reg[`CCM_BIT_TCO2_MSB],        // [R6]
                       bridge_reg[`CCM_BIT_TCO_MSB],         // [R5]
                       bridge_reg[`CCM_BIT_TCG_MSB],         // [R4]
                       bridge_reg[`CCM_BIT_GAIN_B_MSB],      // [R3]
                       bridge_reg[`CCM_BIT_OFFSET_B_MSB]};   // [R2]
    assign sgn_bits = {tsensor_reg[`CCM_BIT_TS2_SGN],        // [R12]
                       tsensor_reg[`CCM_BIT_GAIN_T_SGN],     // [R11]
                       tsensor_reg[`CCM_BIT_OFFSET_T_SGN],   // [R13]
                       bridge_reg[`CCM_BIT_NL_SGN],          // [R8]
                       bridge_reg[`CCM_BIT_TCG2_SGN],        // [R7]
                       bridge_reg[`CCM_BIT_TCO2_SGN],        // [R6]
                       bridge_reg[`CCM_BIT_TCO_SGN],         // [R5]
                       bridge_reg[`CCM_BIT_TCG_SGN],         // [R4]
                       bridge_reg[`CCM_BIT_GAIN_B_SGN],      // [R3]
                       bridge_reg[`CCM_BIT_OFFSET_B_SGN]};   // [R2]

    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : gen_coeff
            ccm_coeff_build u_build (
                .clk_in    (clk_in),
                .reset_in  (reset_in),
                .msb_in    (msb_bits[g]),
                .sign_in   (sgn_bits[g]),
                .low_in    (low_flat[g*16 +: 16]),
                .coeff_out (coeff[g])
            );
        end
    endgenerate

    assign offset_b_out                   = coeff[0];
    assign gain_b_out                     = coeff[1];
    assign gain_tempco_first_out          = coeff[2];
    assign offset_tempco_first_out        = coeff[3];
    assign offset_tempco_second_out       = coeff[4];
    assign gain_tempco_second_out         = coeff[5];
    assign bridge_nonlinear_coeff_out     = coeff[6];
    assign tsensor_offset_out             = coeff[7];
    assign tsensor_gain_out               = coeff[8];
    assign tsensor_second_order_coeff_out = coeff[9];
endmodule
`default_nettype wire

// [test/ccm_coeff_bank_props.sv]
// Concurrent checks on the coefficient word bank ports
`timescale 1ns/10ps
`default_nettype none
module ccm_coeff_bank_props (
    input wire        clk_in,
    input wire        reset_in,
    input wire [4:0]  addr_in,
    input wire [15:0] wr_data_in,
    input wire        wr_en_in,
    input wire        rd_en_in,
    input wire [15:0] rd_data_out,
    input wire [17:0] offset_b_out,
    input wire [17:0] bridge_nonlinear_coeff_out,
    input wire [17:0] tsensor_gain_out,
    input wire        curve_shape_select_out,
    input wire        settle_term_polarity_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ------------------------------------------------------------------
    // Bus sequences
    // ------------------------------------------------------------------
    sequence s_wr3; wr_en_in && addr_in == 5'h03; endsequence
    sequence s_wr4; wr_en_in && addr_in == 5'h04; endsequence
    sequence s_rd3; rd_en_in && addr_in == 5'h03; endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rd_idle_zero: assert property (!rd_en_in |=> rd_data_out == 16'h0000)
        else $error("read data not zero outside read");
    a_rd_unmapped: assert property (rd_en_in && (addr_in < 5'h03 || addr_in > 5'h0e)
        |=> rd_data_out == 16'h0000) else $error("unmapped read not zero");
    a_ts_top_zero: assert property (rd_en_in && addr_in == 5'h04
        |=> rd_data_out[15:6] == 10'h000) else $error("sensor word top bits not zero");
    a_wr_rd_back: assert property (s_wr3 ##1 s_rd3 |=> rd_data_out == $past(wr_data_in, 2))
        else $error("bridge word read back wrong");
    a_curve_track: assert property (s_wr3 |-> ##2
        curve_shape_select_out == $past(wr_data_in[14], 2)) else $error("curve select wrong");
    a_settle_track: assert property (s_wr3 |-> ##2
        settle_term_polarity_out == $past(wr_data_in[15], 2)) else $error("settle sign wrong");
    a_offb_sign: assert property (s_wr3 ##0 wr_data_in[0] |-> ##2 offset_b_out[17:16] != 2'b00
        && offset_b_out[17] == $past(wr_data_in[1], 2)) else $error("offset sign wrong");
    a_nl_sign: assert property (s_wr3 ##0 wr_data_in[12] |-> ##2
        bridge_nonlinear_coeff_out[17:16] != 2'b00
        && bridge_nonlinear_coeff_out[17] == $past(wr_data_in[13], 2)) else $error("nl sign wrong");
    a_tsg_sign: assert property (s_wr4 ##0 wr_data_in[0] |-> ##2
        tsensor_gain_out[17:16] != 2'b00
        && tsensor_gain_out[17] == $past(wr_data_in[1], 2)) else $error("sensor gain sign wrong");
endmodule
bind ccm_coeff_bank ccm_coeff_bank_props u_props (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .offset_b_out(offset_b_out),
    .bridge_nonlinear_coeff_out(bridge_nonlinear_coeff_out),
    .tsensor_gain_out(tsensor_gain_out), .curve_shape_select_out(curve_shape_select_out),
    .settle_term_polarity_out(settle_term_polarity_out));
`default_nettype wire

// [test/ccm_coeff_bank_tb.sv]
// Self-checking bench for the coefficient word bank
`timescale 1ns/10ps
`default_nettype none
module ccm_coeff_bank_tb;
    reg         clk_in;
    reg         reset_in;
    reg  [4:0]  addr_in;
    reg  [15:0] wr_data_in;
    reg         wr_en_in;
    reg         rd_en_in;
    wire [15:0] rd_data_out;
    wire [17:0] co [0:9];
    wire        curve_out;
    wire        settle_out;
    integer     bad_count;
    integer     n_tests;
    integer     i;

    ccm_coeff_bank dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .offset_b_out(co[0]), .gain_b_out(co[1]),
        .gain_tempco_first_out(co[2]), .offset_tempco_first_out(co[3]),
        .offset_tempco_second_out(co[4]), .gain_tempco_second_out(co[5]),
        .bridge_nonlinear_coeff_out(co[6]), .tsensor_offset_out(co[7]),
        .tsensor_gain_out(co[8]), .tsensor_second_order_coeff_out(co[9]),
        .curve_shape_select_out(curve_out), .settle_term_polarity_out(settle_out));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    function [15:0] lo(input [3:0] k);
        lo = 16'h1234 + {12'h000, k} * 16'h0f0f;
    endfunction
    function [3:0] pos(input [3:0] k);
        pos = (k == 4'h7) ? 4'h4 : (k == 4'h8) ? 4'h0 : (k == 4'h9) ? 4'h2 : {k[2:0], 1'b0};
    endfunction
    // Sign-magnitude to signed, msb at p, sign at p+1
    function [17:0] expc(input [15:0] w, input [3:0] p, input [15:0] l);
        reg [17:0] m;
        begin
            m = {1'b0, w[p], l};
            expc = w[p + 1] ? -m : m;
        end
    endfunction
    task check(input [17:0] got, input [17:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge clk_in);
            addr_in <= a;
            wr_data_in <= d;
            wr_en_in <= 1'b1;
            @(posedge clk_in);
            wr_en_in <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [15:0] e);
        begin
            @(posedge clk_in);
            addr_in <= a;
            rd_en_in <= 1'b1;
            @(posedge clk_in);
            rd_en_in <= 1'b0;
            #1;
            check({2'b00, rd_data_out}, {2'b00, e});
        end
    endtask
    task wrap_up;
        begin
            $display("tests %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset pulse, then all outputs and both flag words read zero
    task t_reset;
        begin
            @(posedge clk_in);
            reset_in <= 1'b1;
            repeat (8) @(posedge clk_in);
            reset_in <= 1'b0;
            #1;
            for (i = 0; i < 10; i = i + 1) check(co[i], 18'h00000);
            check({17'h0, curve_out | settle_out}, 18'h0);
            rd(5'h03, 16'h0000);
            rd(5'h04, 16'h0000);
        end
    endtask
    // Fill low words and flag words, then check every coefficient
    task t_pattern(input [15:0] w3, input [15:0] w4);
        begin
            for (i = 0; i < 10; i = i + 1) wr(5'h05 + i, lo(i));
            wr(5'h03, w3);
            wr(5'h04, w4);
            repeat (2) @(posedge clk_in);
            #1;
            for (i = 0; i < 10; i = i + 1)
                check(co[i], expc(i < 7 ? w3 : w4, pos(i), lo(i)));
            check({17'h0, curve_out}, {17'h0, w3[14]});
            check({17'h0, settle_out}, {17'h0, w3[15]});
            rd(5'h03, w3);
            rd(5'h04, w4 & 16'h003f);
            for (i = 0; i < 10; i = i + 1) rd(5'h05 + i, lo(i));
        end
    endtask
    // Unmapped writes ignored, reads zero; write then read with no gap
    task t_edges;
        begin
            wr(5'h10, 16'hbeef);
            wr(5'h02, 16'hbeef);
            rd(5'h10, 16'h0000);
            rd(5'h02, 16'h0000);
            rd(5'h1f, 16'h0000);
            @(posedge clk_in);
            addr_in <= 5'h03;
            wr_data_in <= 16'h9c3d;
            wr_en_in <= 1'b1;
            @(posedge clk_in);
            wr_en_in <= 1'b0;
            rd_en_in <= 1'b1;
            @(posedge clk_in);
            rd_en_in <= 1'b0;
            #1;
            check({2'b00, rd_data_out}, {2'b00, 16'h9c3d});
        end
    endtask

    initial begin
        bad_count = 0;
        n_tests = 0;
        reset_in = 1'b1;
        addr_in = 5'h00;
        wr_data_in = 16'h0000;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        t_reset;
        t_pattern(16'h5555, 16'hffd5);
        t_pattern(16'haaaa, 16'hffea);
        t_pattern(16'hffff, 16'hffff);
        t_edges;
        t_reset;
        wrap_up;
    end
    // Watchdog against a hang
    initial begin
        #20000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
`default_nettype wire
